// file: core/she_pkg.sv
/*
  Shared constants of the hash engine: register map, field positions,
  reset values, cycle counts, round tables and small helper functions.
  Assumes a 32-bit register bus with byte addresses, one word per register.
*/
package she_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_IER = 8'h10;
  localparam logic [7:0] OFS_IDR = 8'h14;
  localparam logic [7:0] OFS_IMR = 8'h18;
  localparam logic [7:0] OFS_ISR = 8'h1c;
  localparam logic [7:0] OFS_IN0 = 8'h40;
  localparam logic [7:0] OFS_IN15 = 8'h7c;
  localparam logic [7:0] OFS_OUT0 = 8'h80;
  localparam logic [7:0] OFS_OUT7 = 8'h9c;
  // Control command bits
  localparam int CTRL_START = 0;
  localparam int CTRL_FIRST = 4;
  localparam int CTRL_SOFT_RESET_CMD = 8;
  // Mode fields and reset value
  localparam int MODE_START_MODE = 0;
  localparam int MODE_PER = 4;
  localparam int MODE_ALGORITHM_SELECT = 8;
  localparam int MODE_DUAL = 16;
  localparam logic [31:0] MODE_RESET = 32'h0000_0100;
  localparam logic [31:0] MODE_WMASK = 32'h0001_0f13;
  // Status fields (ST_RDY and ST_BAD also interrupt mask positions)
  localparam int ST_RDY = 0;
  localparam int ST_BAD = 8;
  localparam int ST_TYPE = 12;
  // Start modes
  localparam logic [1:0] SM_MANUAL = 2'h0;
  localparam logic [1:0] SM_AUTO = 2'h1;
  localparam logic [1:0] SM_WORD0 = 2'h2;
  // Algorithm codes
  localparam logic [3:0] ALG_SHA1 = 4'h0;
  localparam logic [3:0] ALG_SHA224 = 4'h4;
  // Bad access type codes
  localparam logic [2:0] BAD_IN_WR = 3'h0;
  localparam logic [2:0] BAD_OUT_RD = 3'h1;
  localparam logic [2:0] BAD_MODE_WR = 3'h2;
  localparam logic [2:0] BAD_WO_RD = 3'h3;
  // Processing periods in clock cycles: 85, 209, 72, 194
  localparam logic [7:0] PER_SHA1_SHORT = 8'h55;
  localparam logic [7:0] PER_SHA1_LONG = 8'hd1;
  localparam logic [7:0] PER_SHA2_SHORT = 8'h48;
  localparam logic [7:0] PER_SHA2_LONG = 8'hc2;
  localparam logic [7:0] CNT_LAST = 8'h01;
  // Round bookkeeping
  localparam logic [6:0] LAST_SHA1 = 7'h4f;
  localparam logic [6:0] LAST_SHA2 = 7'h3f;
  localparam logic [6:0] SHA1_R20 = 7'h14;
  localparam logic [6:0] SHA1_R40 = 7'h28;
  localparam logic [6:0] SHA1_R60 = 7'h3c;
  localparam logic [3:0] WORD_LAST = 4'hf;
  localparam logic [15:0] ALL_FILLED = 16'hffff;
  // Round constants and initial hash values
  localparam logic [31:0] K1 [4] = '{32'h5a82_7999, 32'h6ed9_eba1, 32'h8f1b_bcdc,
    32'hca62_c1d6};
  localparam logic [31:0] IV1 [8] = '{32'h6745_2301, 32'hefcd_ab89, 32'h98ba_dcfe,
    32'h1032_5476, 32'hc3d2_e1f0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  localparam logic [31:0] IV256 [8] = '{32'h6a09_e667, 32'hbb67_ae85, 32'h3c6e_f372,
    32'ha54f_f53a, 32'h510e_527f, 32'h9b05_688c, 32'h1f83_d9ab, 32'h5be0_cd19};
  localparam logic [31:0] IV224 [8] = '{32'hc105_9ed8, 32'h367c_d507, 32'h3070_dd17,
    32'hf70e_5939, 32'hffc0_0b31, 32'h6858_1511, 32'h64f9_8fa7, 32'hbefa_4fa4};
  localparam logic [31:0] K256 [64] = '{
    32'h428a_2f98, 32'h7137_4491, 32'hb5c0_fbcf, 32'he9b5_dba5, 32'h3956_c25b, 32'h59f1_11f1,
    32'h923f_82a4, 32'hab1c_5ed5, 32'hd807_aa98, 32'h1283_5b01, 32'h2431_85be, 32'h550c_7dc3,
    32'h72be_5d74, 32'h80de_b1fe, 32'h9bdc_06a7, 32'hc19b_f174, 32'he49b_69c1, 32'hefbe_4786,
    32'h0fc1_9dc6, 32'h240c_a1cc, 32'h2de9_2c6f, 32'h4a74_84aa, 32'h5cb0_a9dc, 32'h76f9_88da,
    32'h983e_5152, 32'ha831_c66d, 32'hb003_27c8, 32'hbf59_7fc7, 32'hc6e0_0bf3, 32'hd5a7_9147,
    32'h06ca_6351, 32'h1429_2967, 32'h27b7_0a85, 32'h2e1b_2138, 32'h4d2c_6dfc, 32'h5338_0d13,
    32'h650a_7354, 32'h766a_0abb, 32'h81c2_c92e, 32'h9272_2c85, 32'ha2bf_e8a1, 32'ha81a_664b,
    32'hc24b_8b70, 32'hc76c_51a3, 32'hd192_e819, 32'hd699_0624, 32'hf40e_3585, 32'h106a_a070,
    32'h19a4_c116, 32'h1e37_6c08, 32'h2748_774c, 32'h34b0_bcb5, 32'h391c_0cb3, 32'h4ed8_aa4a,
    32'h5b9c_ca4f, 32'h682e_6ff3, 32'h748f_82ee, 32'h78a5_636f, 32'h84c8_7814, 32'h8cc7_0208,
    32'h90be_fffa, 32'ha450_6ceb, 32'hbef9_a3f7, 32'hc671_78f2};

  // Rotate right by a constant amount
  function automatic logic [31:0] rotr(input logic [31:0] x, input int n);
    rotr = (x >> n) | (x << (32 - n));
  endfunction

  // Swap the four bytes of a word
  function automatic logic [31:0] bswap(input logic [31:0] x);
    bswap = {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      be_merge[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction
endpackage

// file: core/she_round.sv
/*
  Block compression core: one round per clock for SHA1 or SHA256/224,
  chaining value kept in h between blocks.
  Assumes start is a one-cycle pulse given only while the core is idle.
*/
module she_round (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         start,
  input  wire logic         first,
  input  wire logic         use_sha2,
  input  wire logic         use_224,
  input  wire logic [511:0] blk,
  output logic      [255:0] digest
);
  typedef enum logic [1:0] {
    SHE_IDLE = 2'b00,
    SHE_RUN  = 2'b01,
    SHE_ADD  = 2'b11
  } she_core_st_t;

  she_core_st_t state, next_state;
  logic [31:0]  w      [16];
  logic [31:0]  next_w [16];
  logic [31:0]  s      [8];
  logic [31:0]  next_s [8];
  logic [31:0]  h      [8];
  logic [31:0]  next_h [8];
  logic [6:0]   rnd, next_rnd;

  // Round datapath and sequencing
  always_comb begin
    logic [31:0] t1;
    logic [31:0] t2;
    logic [31:0] f;
    logic [31:0] k;
    logic [31:0] wn;
    t1 = '0;
    t2 = '0;
    f = '0;
    k = '0;
    wn = '0;
    next_state = state;
    next_w = w;
    next_s = s;
    next_h = h;
    next_rnd = rnd;
    unique case (state)
      SHE_IDLE: begin
        if (start) begin
          for (int i = 0; i < 16; i++) begin
            next_w[i] = blk[511 - 32*i -: 32];
          end
          // Fresh message restarts from the initial values, else chain
          for (int i = 0; i < 8; i++) begin
            if (first) begin
              next_h[i] = use_224 ? she_pkg::IV224[i] :
                          use_sha2 ? she_pkg::IV256[i] : she_pkg::IV1[i];
            end
            next_s[i] = next_h[i];
          end
          next_rnd = '0;
          next_state = SHE_RUN;
        end
      end
      SHE_RUN: begin
        if (use_sha2) begin
          t1 = s[7] + (she_pkg::rotr(s[4], 6) ^ she_pkg::rotr(s[4], 11)
               ^ she_pkg::rotr(s[4], 25)) + ((s[4] & s[5]) ^ (~s[4] & s[6]))
               + she_pkg::K256[rnd[5:0]] + w[0];
          t2 = (she_pkg::rotr(s[0], 2) ^ she_pkg::rotr(s[0], 13) ^ she_pkg::rotr(s[0], 22))
               + ((s[0] & s[1]) ^ (s[0] & s[2]) ^ (s[1] & s[2]));
          wn = (she_pkg::rotr(w[14], 17) ^ she_pkg::rotr(w[14], 19) ^ (w[14] >> 10)) + w[9]
               + (she_pkg::rotr(w[1], 7) ^ she_pkg::rotr(w[1], 18) ^ (w[1] >> 3)) + w[0];
          for (int i = 1; i < 8; i++) begin
            next_s[i] = s[i-1];
          end
          next_s[0] = t1 + t2;
          next_s[4] = s[3] + t1;
        end else begin
          if (rnd < she_pkg::SHA1_R20) begin
            f = (s[1] & s[2]) | (~s[1] & s[3]);
            k = she_pkg::K1[0];
          end else if (rnd < she_pkg::SHA1_R40) begin
            f = s[1] ^ s[2] ^ s[3];
            k = she_pkg::K1[1];
          end else if (rnd < she_pkg::SHA1_R60) begin
            f = (s[1] & s[2]) | (s[1] & s[3]) | (s[2] & s[3]);
            k = she_pkg::K1[2];
          end else begin
            f = s[1] ^ s[2] ^ s[3];
            k = she_pkg::K1[3];
          end
          t1 = she_pkg::rotr(s[0], 27) + f + s[4] + k + w[0];
          wn = she_pkg::rotr(w[13] ^ w[8] ^ w[2] ^ w[0], 31);
          next_s[0] = t1;
          next_s[1] = s[0];
          next_s[2] = she_pkg::rotr(s[1], 2);
          next_s[3] = s[2];
          next_s[4] = s[3];
        end
        // Sliding message schedule window
        for (int i = 0; i < 15; i++) begin
          next_w[i] = w[i+1];
        end
        next_w[15] = wn;
        next_rnd = rnd + 7'h01;
        if (rnd == (use_sha2 ? she_pkg::LAST_SHA2 : she_pkg::LAST_SHA1)) begin
          next_state = SHE_ADD;
        end
      end
      SHE_ADD: begin
        for (int i = 0; i < 8; i++) begin
          next_h[i] = h[i] + s[i];
        end
        next_state = SHE_IDLE;
      end
      default: next_state = SHE_IDLE;
    endcase
    // Soft reset drops the chain and any round in flight
    if (clr) begin
      next_state = SHE_IDLE;
      for (int i = 0; i < 8; i++) begin
        next_h[i] = '0;
      end
    end
  end

  // Core registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= SHE_IDLE;
      rnd <= '0;
      for (int i = 0; i < 16; i++) begin
        w[i] <= '0;
      end
      for (int i = 0; i < 8; i++) begin
        s[i] <= '0;
        h[i] <= '0;
      end
    end else begin
      state <= next_state;
      rnd <= next_rnd;
      w <= next_w;
      s <= next_s;
      h <= next_h;
    end
  end

  // Digest straight from the chaining registers, word 0 on top
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      digest[255 - 32*i -: 32] = h[i];
    end
  end
endmodule

// file: core/she_ctrl.sv
/*
  Hash engine top: Avalon-MM register slave, input block buffer, start
  modes, processing period timer, status and access checking.
  Assumes one clock, an Avalon master with byte addresses and aligned words.
*/
// Added by the designer: the Avalon-MM register port.
// How it works
// - Only result_ready_flag marks the end of processing, not the DMA.
// - Input words are little-endian and byte-swapped to big-endian internally.
// - Digest words read back byte-swapped to little-endian.
// - Bad accesses set bad_access_flag and record the latest bad_access_type.
// - Detected: DMA input write, output read, mode write while busy, write-only read.
// - Only soft_reset_cmd clears bad_access_flag and bad_access_type.
// - Control bit 0 written one starts a manual hash.
// - Control bit 4 marks the next block as first of a message.
// - Control bit 8 resets the whole engine and its status.
// - start_mode: 0 manual, 1 all words written, 2 word-0 accesses.
// - period_select picks the short or the long processing period.
// - SHA1 block takes 85 or 209 cycles.
// - SHA256 and SHA224 blocks take 72 or 194 cycles.
// - algorithm_select: 0 SHA1, 1 SHA256, 4 SHA224.
// - dual_buffer_enable with mode 2 lets a block load during processing.
// - Start, soft reset or digest read clear result_ready_flag.
// - Bad access codes: 0 input, 1 output, 2 mode, 3 write-only read.
// - Digest reads return zero while processing.
module she_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  output logic             dma_req
);
  // State
  logic [31:0]  mode;
  logic [31:0]  next_mode;
  logic [1:0]   imask;
  logic [1:0]   next_imask;
  logic         rdy;
  logic         next_rdy;
  logic         bad;
  logic         next_bad;
  logic [2:0]   bad_type;
  logic [2:0]   next_bad_type;

  // Block buffer
  logic         first_pend;
  logic         next_first_pend;
  logic [31:0]  inbuf      [16];
  logic [31:0]  next_inbuf [16];
  logic [15:0]  filled;
  logic [15:0]  next_filled;
  logic [3:0]   wptr;
  logic [3:0]   next_wptr;
  logic         start_pend;
  logic         next_start_pend;

  // Timer
  logic         busy;
  logic         next_busy;
  logic [7:0]   cnt;
  logic [7:0]   next_cnt;

  // Bus
  logic         ack;
  logic         next_ack;
  logic [31:0]  next_readdata;
  logic [7:0]   aw;
  logic         wr_go;
  logic         rd_go;
  logic         in_hit;
  logic         out_hit;
  logic [3:0]   in_idx;
  logic [2:0]   out_idx;

  // Decode
  logic [1:0]   smode;
  logic         per_long;
  logic [3:0]   algorithm_select;
  logic         dual;
  logic         sha2;
  logic [7:0]   period;
  logic         launch;
  logic         soft_reset_cmd;
  logic [511:0] blk;
  logic [255:0] digest;

  // Mode field views
  assign smode = mode[she_pkg::MODE_START_MODE +: 2];
  assign per_long = mode[she_pkg::MODE_PER];
  assign algorithm_select = mode[she_pkg::MODE_ALGORITHM_SELECT +: 4];
  assign dual = mode[she_pkg::MODE_DUAL];
  assign sha2 = (algorithm_select != she_pkg::ALG_SHA1);

  // Processing period from algorithm and period_select
  always_comb begin
    if (sha2) begin
      period = per_long ? she_pkg::PER_SHA2_LONG : she_pkg::PER_SHA2_SHORT;
    end else begin
      period = per_long ? she_pkg::PER_SHA1_LONG : she_pkg::PER_SHA1_SHORT;
    end
  end

  // Bus decode; one wait state per access, low address bits ignored
  assign aw = {avs_address[7:2], 2'b00};
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign next_ack = (avs_read | avs_write) & ~ack;
  assign wr_go = avs_write & ack;
  assign rd_go = avs_read & ~ack;
  assign in_hit = (aw >= she_pkg::OFS_IN0) && (aw <= she_pkg::OFS_IN15);
  assign out_hit = (aw >= she_pkg::OFS_OUT0) && (aw <= she_pkg::OFS_OUT7);
  assign in_idx = avs_address[5:2];
  assign out_idx = avs_address[4:2];

  // Control commands decoded from a completing write
  assign soft_reset_cmd = wr_go && (aw == she_pkg::OFS_CTRL)
                 && avs_byteenable[1] && avs_writedata[she_pkg::CTRL_SOFT_RESET_CMD];

  // A pending block launches as soon as the engine is free
  assign launch = start_pend & ~busy;

  // DMA may push a block when one can be taken
  assign dma_req = (smode == she_pkg::SM_WORD0) & ~start_pend & (~busy | dual);
  assign irq = |({bad, rdy} & imask);

  // Block handed to the core, word 0 first
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      blk[511 - 32*i -: 32] = inbuf[i];
    end
  end

  // Read data and read side effects are taken in the first access cycle
  always_comb begin
    next_readdata = avs_readdata;
    if (rd_go) begin
      // Write-only, unmapped and busy digest reads return zero
      next_readdata = '0;
      if (aw == she_pkg::OFS_MODE) begin
        next_readdata = mode;
      end else if (aw == she_pkg::OFS_IMR) begin
        next_readdata[she_pkg::ST_RDY] = imask[0];
        next_readdata[she_pkg::ST_BAD] = imask[1];
      end else if (aw == she_pkg::OFS_ISR) begin
        next_readdata[she_pkg::ST_RDY] = rdy;
        next_readdata[she_pkg::ST_BAD] = bad;
        next_readdata[she_pkg::ST_TYPE +: 3] = bad_type;
      end else if (out_hit && !busy) begin
        next_readdata = she_pkg::bswap(digest[255 - 32*out_idx -: 32]);
      end
    end
  end

  // Engine state: commands, buffer fill, triggers, timer and flags
  always_comb begin
    next_mode = mode;
    next_imask = imask;

    next_rdy = rdy;
    next_bad = bad;
    next_bad_type = bad_type;

    next_first_pend = first_pend;

    next_inbuf = inbuf;
    next_filled = filled;
    next_wptr = wptr;
    next_start_pend = start_pend;

    next_busy = busy;
    next_cnt = cnt;

    // Launch first so a write in the same cycle lands in the fresh buffer
    if (launch) begin
      next_busy = 1'b1;
      next_cnt = period;
      next_start_pend = 1'b0;
      next_first_pend = 1'b0;
      next_filled = '0;
      next_wptr = '0;
    end else if (busy) begin
      next_cnt = cnt - she_pkg::CNT_LAST;
    end

    // Register writes
    if (wr_go) begin
      if (aw == she_pkg::OFS_CTRL) begin
        if (avs_byteenable[0] && avs_writedata[she_pkg::CTRL_START]) begin
          next_start_pend = 1'b1;
          next_rdy = 1'b0;
        end
        if (avs_byteenable[0] && avs_writedata[she_pkg::CTRL_FIRST]) begin
          next_first_pend = 1'b1;
        end
      end else if (aw == she_pkg::OFS_MODE) begin
        if (busy) begin
          // Mode is frozen while a block is in flight
          next_bad = 1'b1;
          next_bad_type = she_pkg::BAD_MODE_WR;
        end else begin
          next_mode = she_pkg::be_merge(mode, avs_writedata, avs_byteenable)
                      & she_pkg::MODE_WMASK;
        end
      end else if (aw == she_pkg::OFS_IER) begin
        next_imask = imask | {avs_writedata[she_pkg::ST_BAD], avs_writedata[she_pkg::ST_RDY]};
      end else if (aw == she_pkg::OFS_IDR) begin
        next_imask = imask & ~{avs_writedata[she_pkg::ST_BAD], avs_writedata[she_pkg::ST_RDY]};
      end else if (in_hit) begin
        if (busy && !(dual && smode == she_pkg::SM_WORD0)) begin
          // Write dropped; only flagged when a DMA mode is active
          if (smode != she_pkg::SM_MANUAL) begin
            next_bad = 1'b1;
            next_bad_type = she_pkg::BAD_IN_WR;
          end
        end else if (smode == she_pkg::SM_WORD0 && in_idx == 4'h0) begin
          // Repeated word-0 writes fill the block in order
          next_inbuf[wptr] = she_pkg::bswap(she_pkg::be_merge(she_pkg::bswap(inbuf[wptr]),
                             avs_writedata, avs_byteenable));
          next_wptr = wptr + 4'h1;
          if (wptr == she_pkg::WORD_LAST) begin
            next_start_pend = 1'b1;
            next_rdy = 1'b0;
          end
        end else begin
          next_inbuf[in_idx] = she_pkg::bswap(she_pkg::be_merge(she_pkg::bswap(inbuf[in_idx]),
                               avs_writedata, avs_byteenable));
          next_filled[in_idx] = 1'b1;
          if (smode == she_pkg::SM_AUTO
              && (filled | (16'h0001 << in_idx)) == she_pkg::ALL_FILLED) begin
            next_start_pend = 1'b1;
            next_rdy = 1'b0;
          end
        end
      end
    end

    // Read side effects
    if (rd_go) begin
      if (out_hit) begin
        if (busy) begin
          next_bad = 1'b1;
          next_bad_type = she_pkg::BAD_OUT_RD;
        end else begin
          next_rdy = 1'b0;
        end
      end else if (in_hit || aw == she_pkg::OFS_CTRL || aw == she_pkg::OFS_IER
                   || aw == she_pkg::OFS_IDR) begin
        next_bad = 1'b1;
        next_bad_type = she_pkg::BAD_WO_RD;
      end
    end

    // End of period sets the ready flag; the set wins over a start or digest-read clear
    if (busy && !launch && cnt == she_pkg::CNT_LAST) begin
      next_busy = 1'b0;
      next_rdy = 1'b1;
    end

    // Soft reset overrides everything, the only clear of the bad flags
    if (soft_reset_cmd) begin
      next_mode = she_pkg::MODE_RESET;
      next_imask = '0;
      next_rdy = 1'b0;
      next_bad = 1'b0;
      next_bad_type = '0;
      next_first_pend = 1'b0;
      next_filled = '0;
      next_wptr = '0;
      next_start_pend = 1'b0;
      next_busy = 1'b0;
      next_cnt = '0;
    end
  end

  // Engine registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode <= she_pkg::MODE_RESET;
      imask <= '0;
      rdy <= 1'b0;
      bad <= 1'b0;
      bad_type <= '0;
      first_pend <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        inbuf[i] <= '0;
      end
      filled <= '0;
      wptr <= '0;
      start_pend <= 1'b0;
      busy <= 1'b0;
      cnt <= '0;
    end else begin
      mode <= next_mode;
      imask <= next_imask;
      rdy <= next_rdy;
      bad <= next_bad;
      bad_type <= next_bad_type;
      first_pend <= next_first_pend;
      inbuf <= next_inbuf;
      filled <= next_filled;
      wptr <= next_wptr;
      start_pend <= next_start_pend;
      busy <= next_busy;
      cnt <= next_cnt;
    end
  end

  // Bus registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      avs_readdata <= '0;
    end else begin
      ack <= next_ack;
      avs_readdata <= next_readdata;
    end
  end

  // Compression core; the block is copied in at launch, freeing the buffer
  she_round u_round (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clr      (soft_reset_cmd),
    .start    (launch),
    .first    (first_pend),
    .use_sha2 (sha2),
    .use_224  (algorithm_select == she_pkg::ALG_SHA224),
    .blk      (blk),
    .digest   (digest)
  );
endmodule

// file: sim/she_host_model.sv
/*
  Host side of the hash engine: processor bus master and a DMA channel.
  Assumes the engine is the only slave on its Avalon port.
*/
module she_host_model (
  input  wire logic        sys_clk,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic        dma_req
);
  logic hang = 1'b0;
  // Idle bus at time zero
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
  end
  // Request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    for (n = 0; n < 16; n++) begin
      @(posedge sys_clk);
      if (!avs_waitrequest) break;
    end
    hang = hang | (n == 16);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_writedata <= ~d; // Stale data must not look valid
  endtask
  // One block per request, fixed target address
  task automatic dma_blk(input logic [31:0] blk [16]);
    logic [31:0] q;
    int n;
    for (n = 0; n < 64 && !dma_req; n++) @(posedge sys_clk);
    hang = hang | !dma_req;
    for (int i = 0; i < 16; i++) acc(1'b1, she_pkg::OFS_IN0, blk[i], q);
  endtask
endmodule

// file: sim/she_ctrl_monitor.sv
/*
  Checker of the hash engine register port and status flags.
  Assumes aligned word accesses from a master that holds its requests.
*/
module she_ctrl_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  logic       done, rd_isr, rd_mode, rd_wo, swr, st;
  logic       prev_wo, bad, clean, next_prev_wo, next_bad, next_clean;
  logic [7:0] cnt, next_cnt;
  // Access decode; cycle count saturates so an old start never looks recent
  always_comb begin
    done = (avs_read | avs_write) & ~avs_waitrequest;
    rd_isr = done & avs_read & (avs_address == she_pkg::OFS_ISR);
    rd_mode = done & avs_read & (avs_address == she_pkg::OFS_MODE);
    rd_wo = done & avs_read & (avs_address < 8'h04 | avs_address[7:3] == 5'h02
            | avs_address[7:6] == 2'h1);
    st = done & avs_write & (avs_address < 8'h04) & avs_byteenable[0];
    swr = st & avs_byteenable[1] & avs_writedata[8];
    st = st & avs_writedata[0];
    next_prev_wo = rd_wo | (prev_wo & ~done);
    next_bad = ~swr & (rd_wo | bad);
    next_clean = swr | (clean & ~rd_wo & ~(done & avs_write));
    next_cnt = st ? 8'h00 : cnt + {7'h00, cnt != 8'hff};
  end
  // Helper state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_wo <= 1'b0;
      bad <= 1'b0;
      clean <= 1'b1;
      cnt <= 8'hff;
    end else begin
      prev_wo <= next_prev_wo;
      bad <= next_bad;
      clean <= next_clean;
      cnt <= next_cnt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wait_one_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state not one cycle");
  wo_zero_a: assert property (rd_wo |-> avs_readdata == 32'h0)
    else $error("write-only read not zero");
  bad_set_a: assert property (rd_isr && bad |-> avs_readdata[8])
    else $error("bad access flag lost");
  bad_type_a: assert property (rd_isr && prev_wo |-> avs_readdata[14:12] == she_pkg::BAD_WO_RD)
    else $error("bad access type wrong");
  soft_reset_cmd_clr_a: assert property (rd_isr && clean |-> avs_readdata[14:0] == 15'h0)
    else $error("status not cleared");
  rdy_early_a: assert property (rd_isr && cnt < 8'h48 |-> !avs_readdata[0])
    else $error("ready too early");
  mode_bits_a: assert property (rd_mode |-> (avs_readdata & ~she_pkg::MODE_WMASK) == 32'h0)
    else $error("mode reserved bits set");
  mode_rst_a: assert property (rd_mode && clean |-> avs_readdata == she_pkg::MODE_RESET)
    else $error("mode not at reset value");
endmodule
bind she_ctrl she_ctrl_monitor mon (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);

// file: sim/tb_secure_hash_engine_control.sv
/*
  Testbench of the hash engine: registers, then the one-block message abc
  in every start mode, algorithm and period.
  Assumes the host model as bus master and the bound checker.
*/
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %0t %h vs %h", $time, g, e); end end
module tb_secure_hash_engine_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, irq, dma_req;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [31:0] abc [16] = '{0: 32'h8063_6261, 15: 32'h1800_0000, default: 32'h0};
  she_ctrl uut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .dma_req);
  she_host_model hm (.sys_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .dma_req);
  // Clock and cycle count
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hm.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    hm.acc(1'b0, a, 32'h0, q);
  endtask
  // Loads abc, checks busy behaviour, period and the little-endian digest
  task automatic hash(input logic [31:0] m, input int p, input int nw, input logic [31:0] e [8]);
    int t;
    int n;
    wr(8'h04, m);
    wr(8'h00, 32'h0000_0010);
    if (m[1]) hm.dma_blk(abc);
    else for (int i = 0; i < 16; i++) wr(8'h40 + 8'(4 * i), abc[i]);
    if (m[1:0] == 2'h0) wr(8'h00, 32'h0000_0001);
    t = cyc;
    rd(8'h80);
    `CHK(q, 32'h0)
    wr(m[1] ? 8'h40 : 8'h04, m);
    rd(8'h1c);
    `CHK({q[14:12], q[8]}, {m[1] ? 3'h0 : 3'h2, 1'b1})
    if (m[1]) wr(8'h10, 32'h0000_0001);
    for (n = 0; n < 90 && q[0] !== 1'b1; n++) rd(8'h1c);
    `CHK((cyc - t) inside {[p + 2:p + 5]}, 1'b1)
    `CHK(irq, m[1])
    for (int i = 0; i < nw; i++) begin
      rd(8'h80 + 8'(4 * i));
      `CHK(q, {e[i][7:0], e[i][15:8], e[i][23:16], e[i][31:24]})
    end
    rd(8'h1c);
    `CHK(q[0], 1'b0)
  endtask
  task t_regs;
    rd(8'h04);
    `CHK(q, 32'h0000_0100)
    rd(8'h00);
    rd(8'h1c);
    `CHK(q, 32'h0000_3100)
    rd(8'h08);
    `CHK(q, 32'h0)
    wr(8'h10, 32'h0000_0100);
    rd(8'h18);
    `CHK({q, irq}, 33'h0_0000_0201)
    wr(8'h00, 32'h0000_0100);
    rd(8'h1c);
    `CHK({q, irq}, 33'h0)
    $display("test regs done");
  endtask
  task t_sha256;
    hash(32'h0000_0100, 72, 8, '{32'hba78_16bf, 32'h8f01_cfea, 32'h4141_40de, 32'h5dae_2223,
      32'hb003_61a3, 32'h9617_7a9c, 32'hb410_ff61, 32'hf200_15ad});
    $display("test sha256 manual done");
  endtask
  task t_sha1_long;
    hash(32'h0000_0011, 209, 5, '{32'ha999_3e36, 32'h4706_816a, 32'hba3e_2571, 32'h7850_c26c,
      32'h9cd0_d89d, 32'h0, 32'h0, 32'h0});
    $display("test sha1 auto done");
  endtask
  task t_sha224_dma;
    hash(32'h0000_0412, 194, 7, '{32'h2309_7d22, 32'h3405_d822, 32'h8642_a477, 32'hbda2_55b3,
      32'h2aad_bce4, 32'hbda0_b3f7, 32'he36c_9da7, 32'h0});
    $display("test sha224 dma done");
  endtask
  task test_done;
    `CHK(hm.hang, 1'b0)
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs;
    t_sha256;
    t_sha1_long;
    t_sha224_dma;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    test_done;
  end
endmodule
